/* File: rtl/lmgc_map.svh */
// Behaviour
// - on-hook monitor enable converts and forwards ring samples
// - line present: near-zero output, level reads all ones
// - no line: output falls to negative full scale, level zero
// - squelch resets ring-input ac coupling network
// - full-wave ring detect, separate positive/negative flags
// - off-hook level reports loop current, zero means inadequate
// - level steps 6 mA with 2 mA hysteresis
// - FCC/Japan: above 155 mA level reads all ones
// - CTR21: level eight or more means excess current
// - speaker mix levels affect speaker output only
// - receive gain selects 0 to 12 dB
// - receive mute silences receive path
// - transmit attenuation selects 0 to 12 dB
// - transmit mute silences transmit path
// - filter select picks FIR default or IIR
`ifndef LMGC_MAP_SVH
`define LMGC_MAP_SVH
`define LMGC_CLK_MHZ        125
`define LMGC_MON_RATE_HZ    8000
`define LMGC_MON_DIV        ((`LMGC_CLK_MHZ * 1000000) / `LMGC_MON_RATE_HZ)
`define LMGC_FIFO_DEPTH     16
`define LMGC_NEG_FULL       16'sh8000
`define LMGC_NEG_FLOOR      16'shC780
`define LMGC_FALL_STEP      16'sh0400
`define LMGC_LVL_ALL_ONES   4'hF
`define LMGC_LVL_MAX_NORMAL 4'hE
`define LMGC_LVL_CTR21_OVL  4'h8
`define LMGC_LC_MIN_MA      9'h00C
`define LMGC_LC_STEP_MA     9'h006
`define LMGC_LC_HYST_MA     9'h002
`define LMGC_LC_OVL_MA      9'h09B
`define LMGC_RING_THRESH    16'sh1000
`define LMGC_DCT_CTR21      2'h2
`define LMGC_GAIN_0DB       12'h100
`define LMGC_GAIN_3DB       12'h16A
`define LMGC_GAIN_6DB       12'h200
`define LMGC_GAIN_9DB       12'h2D4
`define LMGC_GAIN_12DB      12'h400
`define LMGC_SPK_TX_GAIN    12'h01A
`define LMGC_GAIN_CODE_MAX  3'h4
`endif

/* File: rtl/lmgc_pkg.sv */
package lmgc_pkg;
  typedef struct packed {
    logic       monitorEnable;
    logic       squelch;
    logic [2:0] rxGainSelect;
    logic       rxMute;
    logic [2:0] txAttenSelect;
    logic       txMute;
    logic [1:0] speakerTxLevel;
    logic [1:0] speakerRxLevel;
    logic       lowDelayFilterSelect;
    logic       legacyRxGain;
    logic       legacyTxAtten;
    logic [1:0] dcTermMode;
  } lmgc_ctrl_t;

  typedef struct packed {
    logic [3:0] loopCurrentLevel;
    logic       ringDetectPositive;
    logic       ringDetectNegative;
    logic       overload;
    logic       gainCodeReserved;
    logic       couplingReset;
    logic       lowDelayFilterActive;
  } lmgc_status_t;

  typedef enum logic [2:0] {
    LMGC_IDLE    = 3'b001,
    LMGC_PRESENT = 3'b010,
    LMGC_ABSENT  = 3'b100
  } lmgc_mon_t;
endpackage : lmgc_pkg

/* File: rtl/lmgc_fifo.sv */
`timescale 1ns/1ps
module lmgc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("lmgc_fifo: DEPTH must be a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doWrite;
  logic             doRead;

  assign inReady  = (count != DEPTH[AW:0]);
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= rdPtr + 1'b1;
      end
      if (doWrite && !doRead) begin
        count <= count + 1'b1;
      end else if (doRead && !doWrite) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : lmgc_fifo

/* File: rtl/lmgc_top.sv */
`timescale 1ns/1ps
`include "lmgc_map.svh"
module lmgc_top #(
  parameter int MON_DIV    = `LMGC_MON_DIV,
  parameter int FIFO_DEPTH = `LMGC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Host control
  input  wire lmgc_pkg::lmgc_ctrl_t ctrl,
  input  wire logic                ringFlagClear,
  input  wire logic                offHook,
  // Line side sensing, asynchronous
  input  wire logic [15:0]         ringInputs,
  input  wire logic                lineSense,
  input  wire logic [8:0]          loopCurrentMa,
  // Modem data paths
  input  wire logic                rxValid,
  input  wire logic [15:0]         rxSample,
  input  wire logic                txValid,
  input  wire logic [15:0]         txSample,
  output lmgc_pkg::lmgc_status_t   status,
  output logic                     rxOutValid,
  output logic [15:0]              rxOut,
  output logic                     txOutValid,
  output logic [15:0]              txOut,
  output logic [15:0]              speakerOut,
  // Serial data output stream
  output logic                     serialDataOutValid,
  output logic [15:0]              serialDataOut,
  input  wire logic                serialDataOutReady,
  output logic                     monitorOverrun
);
  initial begin
    if (MON_DIV < 2) begin
      $error("lmgc_top: MON_DIV must be at least 2");
    end
  end

  function automatic logic [11:0] gainFactor(input logic [2:0] code);
    case (code)
      3'h0:    gainFactor = `LMGC_GAIN_0DB;
      3'h1:    gainFactor = `LMGC_GAIN_3DB;
      3'h2:    gainFactor = `LMGC_GAIN_6DB;
      3'h3:    gainFactor = `LMGC_GAIN_9DB;
      3'h4:    gainFactor = `LMGC_GAIN_12DB;
      default: gainFactor = `LMGC_GAIN_0DB; // Reserved codes
    endcase
  endfunction : gainFactor

  function automatic logic [15:0] scaleSat(input logic [15:0] s,
                                           input logic [11:0] f);
    logic signed [28:0] prod;
    logic signed [20:0] shifted;
    prod    = $signed(s) * $signed({1'b0, f});
    shifted = prod[28:8];
    if (shifted > 21'sd32767) begin
      scaleSat = 16'h7FFF;
    end else if (shifted < -21'sd32768) begin
      scaleSat = 16'h8000;
    end else begin
      scaleSat = shifted[15:0];
    end
  endfunction : scaleSat

  // Two-stage synchronisers for line-side inputs
  logic [15:0] ringMeta;
  logic [15:0] ringSync;
  logic        senseMeta;
  logic        senseSync;
  logic [8:0]  currentMeta;
  logic [8:0]  currentSync;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ringMeta    <= 16'h0000;
      ringSync    <= 16'h0000;
      senseMeta   <= 1'b0;
      senseSync   <= 1'b0;
      currentMeta <= 9'h000;
      currentSync <= 9'h000;
    end else begin
      ringMeta    <= ringInputs;
      ringSync    <= ringMeta;
      senseMeta   <= lineSense;
      senseSync   <= senseMeta;
      currentMeta <= loopCurrentMa;
      currentSync <= currentMeta;
    end
  end

  // Low-power converter sample strobe
  logic [$clog2(MON_DIV)-1:0] divCount;
  logic                       monTick;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divCount <= '0;
      monTick  <= 1'b0;
    end else if (divCount == ($clog2(MON_DIV))'(MON_DIV - 1)) begin
      divCount <= '0;
      monTick  <= 1'b1;
    end else begin
      divCount <= divCount + 1'b1;
      monTick  <= 1'b0;
    end
  end

  // Line monitor state and sample generation
  lmgc_pkg::lmgc_mon_t monState;
  lmgc_pkg::lmgc_mon_t next_monState;
  logic                monActive;
  logic [15:0]         monSample;
  logic                monPush;
  logic                fifoInReady;
  assign monActive = ctrl.monitorEnable && !offHook && !ctrl.squelch;
  always_comb begin
    case (monState)
      lmgc_pkg::LMGC_IDLE,
      lmgc_pkg::LMGC_PRESENT,
      lmgc_pkg::LMGC_ABSENT:
        next_monState = !monActive ? lmgc_pkg::LMGC_IDLE :
                        senseSync ? lmgc_pkg::LMGC_PRESENT :
                        lmgc_pkg::LMGC_ABSENT;
      default:
        next_monState = lmgc_pkg::LMGC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      monState <= lmgc_pkg::LMGC_IDLE;
    end else begin
      monState <= next_monState;
    end
  end

  // Missing line drags output down and holds it at full negative scale
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      monSample <= 16'h0000;
      monPush   <= 1'b0;
    end else begin
      monPush <= monTick && (monState != lmgc_pkg::LMGC_IDLE);
      if (monTick) begin
        case (monState)
          lmgc_pkg::LMGC_PRESENT:
            monSample <= ringSync;
          lmgc_pkg::LMGC_ABSENT:
            if ($signed(monSample) < ($signed(`LMGC_NEG_FULL) +
                                      $signed(`LMGC_FALL_STEP))) begin
              monSample <= `LMGC_NEG_FULL;
            end else begin
              monSample <= monSample - `LMGC_FALL_STEP;
            end
          default:
            monSample <= 16'h0000;
        endcase
      end
    end
  end

  // A stalled host loses samples rather than stalling the converter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      monitorOverrun <= 1'b0;
    end else if (monPush && !fifoInReady) begin
      monitorOverrun <= 1'b1;
    end else if (!monActive) begin
      monitorOverrun <= 1'b0;
    end
  end

  logic        fifoOutValid;
  logic [15:0] fifoOutData;
  logic        fifoPop;
  assign fifoPop = fifoOutValid && (!serialDataOutValid || serialDataOutReady);

  lmgc_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inValid  (monPush),
    .inReady  (fifoInReady),
    .inData   (monSample),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      serialDataOutValid <= 1'b0;
      serialDataOut      <= 16'h0000;
    end else if (fifoPop) begin
      serialDataOutValid <= 1'b1;
      serialDataOut      <= fifoOutData;
    end else if (serialDataOutReady) begin
      serialDataOutValid <= 1'b0;
    end
  end

  // Loop current level with hysteresis
  logic [3:0] offHookLevel;
  logic [8:0] levelLow;
  logic [8:0] levelHigh;
  assign levelLow  = `LMGC_LC_MIN_MA +
                     9'(offHookLevel - 4'h1) * `LMGC_LC_STEP_MA;
  assign levelHigh = `LMGC_LC_MIN_MA + 9'(offHookLevel) * `LMGC_LC_STEP_MA;

  always_ff @(posedge clk_sys) begin
    if (rst || !offHook) begin
      offHookLevel <= 4'h0;
    end else if (offHookLevel == 4'h0) begin
      if (currentSync >= `LMGC_LC_MIN_MA + `LMGC_LC_HYST_MA) begin
        offHookLevel <= 4'h1;
      end
    end else if (currentSync < levelLow - `LMGC_LC_HYST_MA) begin
      offHookLevel <= offHookLevel - 4'h1;
    end else if (currentSync >= levelHigh + `LMGC_LC_HYST_MA &&
                 offHookLevel != `LMGC_LVL_MAX_NORMAL) begin
      offHookLevel <= offHookLevel + 4'h1;
    end
  end

  // Status register
  logic [3:0] next_level;
  logic       overCurrent;
  assign overCurrent = ctrl.dcTermMode != `LMGC_DCT_CTR21 &&
                       currentSync > `LMGC_LC_OVL_MA;

  always_comb begin
    if (!offHook) begin
      next_level = (monState == lmgc_pkg::LMGC_PRESENT) ?
                   `LMGC_LVL_ALL_ONES : 4'h0;
    end else if (overCurrent) begin
      next_level = `LMGC_LVL_ALL_ONES;
    end else begin
      next_level = offHookLevel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status.loopCurrentLevel <= 4'h0;
      status.overload         <= 1'b0;
    end else begin
      status.loopCurrentLevel <= next_level;
      status.overload <= offHook && (overCurrent ||
                         (ctrl.dcTermMode == `LMGC_DCT_CTR21 &&
                          offHookLevel >= `LMGC_LVL_CTR21_OVL));
    end
  end

  // Full-wave ring detection, sticky until host clears or off-hook; set wins
  logic ringPos;
  logic ringNeg;
  assign ringPos = $signed(ringSync) > $signed(`LMGC_RING_THRESH);
  assign ringNeg = $signed(ringSync) < -$signed(`LMGC_RING_THRESH);

  always_ff @(posedge clk_sys) begin
    if (rst || offHook) begin
      status.ringDetectPositive <= 1'b0;
      status.ringDetectNegative <= 1'b0;
    end else begin
      status.ringDetectPositive <= ringPos ||
        (status.ringDetectPositive && !ringFlagClear);
      status.ringDetectNegative <= ringNeg ||
        (status.ringDetectNegative && !ringFlagClear);
    end
  end

  // Configuration echoes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status.couplingReset        <= 1'b0;
      status.lowDelayFilterActive <= 1'b0;
      status.gainCodeReserved     <= 1'b0;
    end else begin
      status.couplingReset        <= ctrl.squelch;
      status.lowDelayFilterActive <= ctrl.lowDelayFilterSelect;
      status.gainCodeReserved <=
        ctrl.rxGainSelect > `LMGC_GAIN_CODE_MAX ||
        ctrl.txAttenSelect > `LMGC_GAIN_CODE_MAX;
    end
  end

  // Receive and transmit paths; legacy bits are ignored here
  logic [15:0] rxScaled;
  logic [15:0] txScaled;
  logic [11:0] txFactor;
  assign rxScaled = scaleSat(rxSample, gainFactor(ctrl.rxGainSelect));
  // Widened so the unity-squared numerator cannot wrap to zero
  assign txFactor = 12'((17'(`LMGC_GAIN_0DB) * 17'(`LMGC_GAIN_0DB)) /
                        17'(gainFactor(ctrl.txAttenSelect)));
  assign txScaled = scaleSat(txSample, txFactor);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxOutValid <= 1'b0;
      rxOut      <= 16'h0000;
      txOutValid <= 1'b0;
      txOut      <= 16'h0000;
    end else begin
      rxOutValid <= rxValid;
      txOutValid <= txValid;
      if (rxValid) begin
        rxOut <= ctrl.rxMute ? 16'h0000 : rxScaled;
      end
      if (txValid) begin
        txOut <= ctrl.txMute ? 16'h0000 : txScaled;
      end
    end
  end

  // Speaker mix taps the paths after gain; levels never reach the modem data
  logic [15:0] spkRx;
  logic [15:0] spkTx;
  logic [16:0] spkSum;

  assign spkRx  = (ctrl.speakerRxLevel == 2'h0) ? 16'h0000 :
                  16'($signed(rxOut) >>> (2'h3 - ctrl.speakerRxLevel));
  assign spkTx  = (ctrl.speakerTxLevel == 2'h0) ? 16'h0000 :
                  16'($signed(scaleSat(txOut, `LMGC_SPK_TX_GAIN)) >>>
                      (2'h3 - ctrl.speakerTxLevel));
  assign spkSum = 17'($signed(spkRx) + $signed(spkTx));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      speakerOut <= 16'h0000;
    end else begin
      speakerOut <= spkSum[16:15] == 2'b01 ? 16'h7FFF :
                    spkSum[16:15] == 2'b10 ? 16'h8000 :
                    spkSum[15:0];
    end
  end
endmodule : lmgc_top

/* File: sim/lmgc_chk.sv */
`timescale 1ns/1ps
module lmgc_chk #(
  parameter int MON_DIV    = 8,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rst,
  // Inputs watched
  input wire lmgc_pkg::lmgc_ctrl_t   ctrl,
  input wire logic                   offHook,
  input wire logic [8:0]             loopCurrentMa,
  input wire logic                   rxValid,
  input wire logic [15:0]            rxSample,
  input wire logic                   txValid,
  input wire logic                   serialDataOutReady,
  // Outputs watched
  input wire lmgc_pkg::lmgc_status_t status,
  input wire logic                   rxOutValid,
  input wire logic [15:0]            rxOut,
  input wire logic                   txOutValid,
  input wire logic [15:0]            txOut,
  input wire logic                   serialDataOutValid,
  input wire logic [15:0]            serialDataOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_rx_mute:
  assert property (rxValid && ctrl.rxMute |=> rxOutValid && rxOut == 16'h0000)
    else $error("rx mute let data through");
  chk_tx_mute:
  assert property (txValid && ctrl.txMute |=> txOutValid && txOut == 16'h0000)
    else $error("tx mute let data through");
  chk_rx_unity:
  assert property (rxValid && !ctrl.rxMute && ctrl.rxGainSelect == 3'h0
    |=> rxOutValid && rxOut == $past(rxSample))
    else $error("rx 0 dB path altered the sample");
  chk_code_reserved:
  assert property ((ctrl.rxGainSelect > 3'h4) [*3]
    |-> status.gainCodeReserved)
    else $error("reserved gain code not flagged");
  chk_filter_follow:
  assert property ($rose(ctrl.lowDelayFilterSelect)
    |-> ##[1:3] status.lowDelayFilterActive)
    else $error("filter select not applied");
  chk_squelch_reset:
  assert property ($rose(ctrl.squelch) |=> status.couplingReset)
    else $error("squelch did not reset coupling");
  chk_onhook_idle:
  assert property ((!offHook && !ctrl.monitorEnable) [*5]
    |-> status.loopCurrentLevel == 4'h0)
    else $error("on-hook level not zero without monitor");
  chk_fcc_overload:
  assert property ((offHook && ctrl.dcTermMode != 2'h2
    && loopCurrentMa > 9'h09B) [*6]
    |-> status.loopCurrentLevel == 4'hF && status.overload)
    else $error("overload not reported");
  chk_stream_hold:
  assert property (serialDataOutValid && !serialDataOutReady
    |=> serialDataOutValid && $stable(serialDataOut))
    else $error("stream word dropped while stalled");
endmodule : lmgc_chk

bind lmgc_top lmgc_chk #(.MON_DIV(MON_DIV), .FIFO_DEPTH(FIFO_DEPTH)) chk_u (
  .clk_sys, .rst, .ctrl, .offHook, .loopCurrentMa, .rxValid, .rxSample,
  .txValid, .serialDataOutReady, .status, .rxOutValid, .rxOut, .txOutValid,
  .txOut, .serialDataOutValid, .serialDataOut);

/* File: sim/lmgc_host_model.sv */
`timescale 1ns/1ps
module lmgc_host_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Stream from the block
  input  wire logic        serialDataOutValid,
  input  wire logic [15:0] serialDataOut,
  output logic             serialDataOutReady,
  // Pacing and capture
  input  wire logic        stall,
  input  wire logic        slow,
  output logic [15:0]      wordCount,
  output logic [15:0]      lastWord
);
  // Ready moves only after an edge; slow mode raises ready every other cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      serialDataOutReady <= 1'b0;
    end else begin
      serialDataOutReady <= !stall && (!slow || !serialDataOutReady);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wordCount <= 16'h0000;
      lastWord  <= 16'h0000;
    end else if (serialDataOutValid && serialDataOutReady) begin
      wordCount <= wordCount + 16'h0001;
      lastWord  <= serialDataOut;
    end
  end
endmodule : lmgc_host_model

/* File: sim/lmgc_top_test.sv */
`timescale 1ns/1ps
module lmgc_top_test;
  localparam int SQ_CYC  = 125; // Squelch hold, shortened from 1 ms
  localparam int RNG_CYC = 40;  // Ring wait, shortened from 40 ms
  logic clk_sys = 1'b0, rst = 1'b1, offHook = 1'b0, lineSense = 1'b0;
  logic ringFlagClear = 1'b0, rxValid = 1'b0, txValid = 1'b0;
  logic stall = 1'b0, slow = 1'b0;
  logic [15:0] ringInputs = 16'h0000, rxSample = 16'h0000;
  logic [15:0] txSample = 16'h0000;
  logic [8:0]  loopCurrentMa = 9'h000;
  lmgc_pkg::lmgc_ctrl_t ctrl = '0; // Legacy bits stay zero
  lmgc_pkg::lmgc_status_t status;
  logic rxOutValid, txOutValid, serialDataOutValid, serialDataOutReady;
  logic monitorOverrun;
  logic [15:0] rxOut, txOut, speakerOut, serialDataOut, wordCount, lastWord;
  int bad_count = 0, checks_done = 0, cycles = 0;
  logic [15:0] rxTable [8] = '{16'h0100, 16'h016A, 16'h0200, 16'h02D4,
                               16'h0400, 16'h0100, 16'h0100, 16'h0100};
  logic [15:0] txTable [8] = '{16'h0100, 16'h00B5, 16'h0080, 16'h005A,
                               16'h0040, 16'h0100, 16'h0100, 16'h0100};
  // Packed as mode, current in mA, expected level, expected overload
  logic [15:0] lcTable [10] = '{16'h01A0, 16'h01C2, 16'h03C6, 16'h02E6,
    16'h02A4, 16'h141F, 16'h941D, 16'h8793, 16'h86F1, 16'h864E};

  lmgc_top #(.MON_DIV(8), .FIFO_DEPTH(16)) dut_u (
    .clk_sys, .rst, .ctrl, .ringFlagClear, .offHook, .ringInputs,
    .lineSense, .loopCurrentMa, .rxValid, .rxSample, .txValid, .txSample,
    .status, .rxOutValid, .rxOut, .txOutValid, .txOut, .speakerOut,
    .serialDataOutValid, .serialDataOut, .serialDataOutReady,
    .monitorOverrun);
  lmgc_host_model host_u (
    .clk_sys, .rst, .serialDataOutValid, .serialDataOut,
    .serialDataOutReady, .stall, .slow, .wordCount, .lastWord);

  initial forever #4 clk_sys = ~clk_sys;

  task end_of_test;
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task settle(input int n);
    tick(n);
    #1;
  endtask : settle

  task send(input logic [15:0] s);
    @(posedge clk_sys);
    rxValid  <= 1'b1;
    txValid  <= 1'b1;
    rxSample <= s;
    txSample <= s;
    @(posedge clk_sys);
    rxValid <= 1'b0;
    txValid <= 1'b0;
    #1;
  endtask : send

  // A hang is cut short well past the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    tick(3);
    rst <= 1'b0;
    settle(2);
    check(16'(status), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      tick(1);
      ctrl.rxGainSelect  <= i[2:0];
      ctrl.txAttenSelect <= i[2:0];
      send(16'h0100);
      check(rxOut, rxTable[i]);
      check(txOut, txTable[i]);
      settle(2);
      check(16'(status.gainCodeReserved), 16'(i > 4));
    end
    tick(1);
    ctrl.rxGainSelect <= 3'h4;
    send(16'h4000);
    check(rxOut, 16'h7FFF);
    send(16'hC000);
    check(rxOut, 16'h8000);
    tick(1);
    ctrl.rxGainSelect  <= 3'h0;
    ctrl.txAttenSelect <= 3'h0;
    ctrl.rxMute        <= 1'b1;
    ctrl.txMute        <= 1'b1;
    send(16'h1234);
    check(rxOut, 16'h0000);
    check(txOut, 16'h0000);
    for (int j = 3; j >= 0; j--) begin
      tick(1);
      ctrl.rxMute         <= 1'b0;
      ctrl.txMute         <= 1'b0;
      ctrl.speakerTxLevel <= j[1:0];
      ctrl.speakerRxLevel <= j[1:0];
      send(16'h0100);
      check(rxOut, 16'h0100);
      check(txOut, 16'h0100);
      settle(1);
      check(speakerOut, (j == 0) ? 16'h0000 : 16'((16'h0100 >> (3 - j)) +
            (16'h001A >> (3 - j))));
    end
    settle(2);
    check(speakerOut, 16'h0000);
    tick(1);
    ctrl.lowDelayFilterSelect <= 1'b1;
    settle(3);
    check(16'(status.lowDelayFilterActive), 16'h0001);
    tick(1);
    ringInputs <= 16'h2000;
    settle(6);
    check(16'({status.ringDetectPositive, status.ringDetectNegative}),
          16'h0002);
    // Another edge inside the wait means a ring, not a reversal
    tick(1);
    ringInputs <= 16'hE000;
    settle(RNG_CYC);
    check(16'({status.ringDetectPositive, status.ringDetectNegative}),
          16'h0003);
    tick(1);
    ringInputs    <= 16'h0000;
    ringFlagClear <= 1'b1;
    tick(4);
    ringFlagClear <= 1'b0;
    settle(2);
    check(16'({status.ringDetectPositive, status.ringDetectNegative}),
          16'h0000);
    tick(1);
    ringInputs <= 16'hE000;
    settle(RNG_CYC);
    check(16'({status.ringDetectPositive, status.ringDetectNegative}),
          16'h0001);
    tick(1);
    ringInputs   <= 16'h0010;
    lineSense    <= 1'b1;
    ctrl.squelch <= 1'b1;
    settle(2);
    check(16'(status.couplingReset), 16'h0001);
    tick(SQ_CYC);
    ctrl.squelch       <= 1'b0;
    ctrl.monitorEnable <= 1'b1;
    repeat (500) if (wordCount < 16'h0006) @(posedge clk_sys);
    #1;
    check(lastWord, 16'h0010);
    check(16'(status.loopCurrentLevel), 16'h000F);
    tick(1);
    lineSense <= 1'b0;
    slow      <= 1'b1;
    settle(600);
    check(lastWord, 16'h8000);
    check(16'(status.loopCurrentLevel), 16'h0000);
    tick(1);
    stall <= 1'b1;
    settle(192);
    check(16'(monitorOverrun), 16'h0001);
    tick(1);
    stall              <= 1'b0;
    ctrl.monitorEnable <= 1'b0;
    repeat (400) if (serialDataOutValid) @(posedge clk_sys);
    settle(4);
    check(16'(monitorOverrun), 16'h0000);
    check(16'(serialDataOutValid), 16'h0000);
    tick(1);
    offHook <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      tick(1);
      ctrl.dcTermMode <= lcTable[i][15:14];
      loopCurrentMa   <= lcTable[i][13:5];
      settle(30);
      check(16'(status.loopCurrentLevel),
            16'(lcTable[i][4:1]));
      check(16'(status.overload), 16'(lcTable[i][0]));
    end
    end_of_test();
  end
endmodule : lmgc_top_test
